// *** rtl/tpsmr_pkg.sv ***
// Constants and types of the ten-port stream merge router.
// Assumes a single pclk domain and an APB register slave with 32-bit data.
package tpsmr_pkg;

  // ****************************************************************
  // Stream geometry
  // ****************************************************************
  localparam int NUM_PORTS = 10;
  localparam int WORD_W = 24;
  localparam int SLOT_W = 7;
  localparam logic [SLOT_W-1:0] AUDIO_SLOTS = 7'h40;
  localparam logic [SLOT_W-1:0] CTRL_CHANNELS = 7'h0E;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 7'h4D;
  localparam logic [SLOT_W-1:0] SLOT_RST = 7'h00;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
  localparam int CTRL_ADVANCE_BIT = 0;
  localparam int STATUS_MANUAL_BIT = 0;
  localparam int STATUS_PRESET_LSB = 1;
  localparam int STATUS_RED_BIT = 4;
  localparam int STATUS_ACTIVE_LSB = 16;

  // ****************************************************************
  // Routing presets
  // ****************************************************************
  typedef enum logic [2:0] {
    TPSMR_PRESET_A = 3'h1,
    TPSMR_PRESET_B = 3'h2,
    TPSMR_PRESET_C = 3'h4
  } tpsmr_preset_t;

  localparam tpsmr_preset_t PRESET_RST = TPSMR_PRESET_A;

endpackage

// *** rtl/tpsmr_router.sv ***
// Routing core of a ten-port stream merge hub with APB status and control.
// Assumes receive streams arrive on pclk, slot-aligned to slot_idx;
// the mode line and the button are asynchronous pins.
//
// Behaviour
// - Auto mode: all ports feed the merge, all ports send it.
// - Preset A: merge all ports, send merged stream on all ten ports.
// - Preset B: merge ports 1-9 audio, send only on port 10.
// - Preset B: port 10 received stream goes out on ports 1-9.
// - Preset C: merge ports 1-8, send on ports 8-10.
// - Preset C: port 8 feeds the merge and gets the whole merge back.
// - Preset C: ports 9 and 10 feed ports 1-7 as redundant path.
// - Mode comes from the network master; auto indicator lit in auto.
// - Manual mode lights manual indicator and selected preset indicator.
// - Exactly one preset is selected at all times, also after reset.
// - Each button press steps preset A, B, C, A; used in manual.
// - Port activity indicator follows valid stream on that receive side.
// - Fourteen control channels have own slots, merged with audio.
// - Preset B still merges and distributes control channels of all ports.
// - Auto merge offers 64 audio slots reachable from every port.
// - Manual mode carries a 64-slot stream in each direction.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps

module tpsmr_router
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Network mode and local button pins
  input wire logic net_manual,
  input wire logic cfg_button,
  // Receive side of the ten ports
  input wire logic [9:0] rx_valid,
  input wire logic [9:0] rx_occ,
  input wire logic [9:0][23:0] rx_data,
  // Transmit side of the ten ports
  output logic [6:0] slot_idx,
  output logic tx_sof,
  output logic [6:0] tx_slot,
  output logic [9:0] tx_occ,
  output logic [9:0][23:0] tx_data,
  // Indicators
  output logic led_auto,
  output logic led_manual,
  output logic [2:0] led_preset,
  output logic [9:0] led_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Lowest contributing port that occupies the slot wins it
  function automatic logic [24:0] merge_slot(input logic [9:0] mask, input logic [9:0] occ,
                                            input logic [9:0][23:0] data);
    logic [24:0] r;
    r = 25'h0000000;
    for (int i = 9; i >= 0; i--)
    begin
      if (mask[i] && occ[i])
      begin
        r = {1'b1, data[i]};
      end
    end
    return r;
  endfunction

  function automatic tpsmr_pkg::tpsmr_preset_t step_preset(input tpsmr_pkg::tpsmr_preset_t p);
    tpsmr_pkg::tpsmr_preset_t n;
    n = tpsmr_pkg::TPSMR_PRESET_A;
    unique case (p)
      tpsmr_pkg::TPSMR_PRESET_A: n = tpsmr_pkg::TPSMR_PRESET_B;
      tpsmr_pkg::TPSMR_PRESET_B: n = tpsmr_pkg::TPSMR_PRESET_C;
      tpsmr_pkg::TPSMR_PRESET_C: n = tpsmr_pkg::TPSMR_PRESET_A;
      default: n = tpsmr_pkg::TPSMR_PRESET_A;
    endcase
    return n;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic mode_meta;
  logic manual_q;
  logic btn_meta;
  logic btn_q;
  logic btn_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_meta <= 1'b0;
      manual_q <= 1'b0;
      btn_meta <= 1'b0;
      btn_q <= 1'b0;
      btn_prev <= 1'b0;
    end
    else
    begin
      mode_meta <= net_manual;
      manual_q <= mode_meta;
      btn_meta <= cfg_button;
      btn_q <= btn_meta;
      btn_prev <= btn_q;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic apb_done;
  logic apb_adv;
  logic [31:0] status_word;
  tpsmr_pkg::tpsmr_preset_t preset;
  logic red_p10;
  assign apb_done = psel && penable && pready;
  assign apb_adv = apb_done && pwrite && (paddr == tpsmr_pkg::REG_CTRL) &&
                   pwdata[tpsmr_pkg::CTRL_ADVANCE_BIT];

  always_comb
  begin
    status_word = 32'h00000000;
    status_word[tpsmr_pkg::STATUS_MANUAL_BIT] = manual_q;
    status_word[tpsmr_pkg::STATUS_PRESET_LSB +: 3] = preset;
    status_word[tpsmr_pkg::STATUS_RED_BIT] = red_p10;
    status_word[tpsmr_pkg::STATUS_ACTIVE_LSB +: 10] = rx_valid;
  end

  // One wait state: answer in the cycle after the access phase starts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata <= (!pwrite && paddr == tpsmr_pkg::REG_STATUS) ? status_word : 32'h00000000;
        pslverr <= (paddr != tpsmr_pkg::REG_CTRL) && (paddr != tpsmr_pkg::REG_STATUS);
      end
    end
  end

  // ****************************************************************
  // Preset selection
  // ****************************************************************
  logic advance;
  assign advance = (btn_q && !btn_prev) || apb_adv;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      preset <= tpsmr_pkg::PRESET_RST;
    end
    else if (advance)
    begin
      preset <= step_preset(preset);
    end
  end

  // ****************************************************************
  // Frame timing
  // ****************************************************************
  logic is_ctrl;
  assign is_ctrl = slot_idx >= tpsmr_pkg::AUDIO_SLOTS;

  // Redundant source chosen before slot 0 so a frame never mixes sources
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slot_idx <= tpsmr_pkg::SLOT_RST;
      red_p10 <= 1'b0;
    end
    else if (slot_idx == tpsmr_pkg::LAST_SLOT)
    begin
      slot_idx <= tpsmr_pkg::SLOT_RST;
      red_p10 <= !rx_valid[8];
    end
    else
    begin
      slot_idx <= slot_idx + 7'h01;
    end
  end

  // ****************************************************************
  // Merge and distribution
  // ****************************************************************
  logic [9:0] live_occ;
  logic [24:0] mrg_all;
  logic [24:0] mrg_19;
  logic [24:0] mrg_18;
  logic [24:0] p10_word;
  logic [24:0] red_word;
  logic [9:0][24:0] next_tx;

  assign live_occ = rx_occ & rx_valid;
  assign mrg_all = merge_slot(10'h3FF, live_occ, rx_data);
  assign mrg_19 = merge_slot(10'h1FF, live_occ, rx_data);
  assign mrg_18 = merge_slot(10'h0FF, live_occ, rx_data);
  assign p10_word = {live_occ[9], rx_data[9]};
  assign red_word = red_p10 ? p10_word : {live_occ[8], rx_data[8]};

  always_comb
  begin
    next_tx = {10{mrg_all}};
    if (manual_q)
    begin
      unique case (preset)
        tpsmr_pkg::TPSMR_PRESET_A: next_tx[0] = mrg_all;
        tpsmr_pkg::TPSMR_PRESET_B:
        begin
          if (!is_ctrl)
          begin
            next_tx[8:0] = {9{p10_word}};
            next_tx[9] = mrg_19;
          end
        end
        tpsmr_pkg::TPSMR_PRESET_C:
        begin
          next_tx[6:0] = {7{red_word}};
          next_tx[9:7] = {3{mrg_18}};
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_occ <= 10'h000;
      tx_data <= '0;
      tx_slot <= tpsmr_pkg::SLOT_RST;
      tx_sof <= 1'b0;
    end
    else
    begin
      for (int p = 0; p < 10; p++)
      begin
        tx_occ[p] <= next_tx[p][24];
        tx_data[p] <= next_tx[p][23:0];
      end
      tx_slot <= slot_idx;
      tx_sof <= slot_idx == tpsmr_pkg::SLOT_RST;
    end
  end

  // ****************************************************************
  // Indicators
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_auto <= 1'b0;
      led_manual <= 1'b0;
      led_preset <= tpsmr_pkg::PRESET_RST;
      led_active <= 10'h000;
    end
    else
    begin
      led_auto <= !manual_q;
      led_manual <= manual_q;
      led_preset <= preset;
      led_active <= rx_valid;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [9:0][24:0] tx_chk;
  always_comb
  begin
    for (int p = 0; p < 10; p++)
    begin
      tx_chk[p] = {tx_occ[p], tx_data[p]};
    end
  end
  wire logic in_a = manual_q && preset == tpsmr_pkg::TPSMR_PRESET_A;
  wire logic in_b = manual_q && preset == tpsmr_pkg::TPSMR_PRESET_B;
  wire logic in_c = manual_q && preset == tpsmr_pkg::TPSMR_PRESET_C;
  a_auto_fanout_all: assert property ($past(!manual_q) && $past(presetn)
    |-> tx_chk == {10{$past(mrg_all)}}) else $error("auto mode fanout wrong");
  a_preset_a_fanout: assert property ($past(in_a) |-> tx_chk == {10{$past(mrg_all)}})
    else $error("preset A fanout wrong");
  a_preset_b_merge: assert property ($past(in_b && !is_ctrl)
    |-> tx_chk[9] == $past(mrg_19)) else $error("preset B merge wrong");
  a_preset_b_return: assert property ($past(in_b && !is_ctrl)
    |-> tx_chk[8:0] == {9{$past(p10_word)}}) else $error("preset B return");
  a_preset_b_ctrl: assert property ($past(in_b && is_ctrl)
    |-> tx_chk == {10{$past(mrg_all)}}) else $error("preset B control");
  a_preset_c_merge: assert property ($past(in_c)
    |-> tx_chk[9:7] == {3{$past(mrg_18)}}) else $error("preset C merge wrong");
  a_preset_c_red: assert property ($past(in_c)
    |-> tx_chk[6:0] == {7{$past(red_word)}}) else $error("preset C redundant");
  a_red_frame_switch: assert property ($changed(red_p10)
    |-> $past(slot_idx) == tpsmr_pkg::LAST_SLOT) else $error("redundant switch mid frame");
  a_red_prefers_p9: assert property (slot_idx == tpsmr_pkg::LAST_SLOT && rx_valid[8]
    |=> !red_p10) else $error("redundant path ignores port 9");
  a_mode_leds: assert property ($past(presetn) |-> led_manual != led_auto
    && led_manual == $past(manual_q)) else $error("mode indicators wrong");
  a_preset_onehot: assert property ($onehot(preset) && $onehot(led_preset))
    else $error("preset not one-hot");
  a_preset_step: assert property (advance |=> preset == step_preset($past(preset)))
    else $error("preset step wrong");
  a_activity_leds: assert property ($past(presetn) |-> led_active == $past(rx_valid))
    else $error("activity indicator wrong");
  a_frame_wrap: assert property (slot_idx == tpsmr_pkg::LAST_SLOT
    |=> slot_idx == tpsmr_pkg::SLOT_RST ##1 tx_sof) else $error("frame length wrong");
  a_slot_owned: assert property (!manual_q && live_occ[0]
    |=> tx_occ[9] && tx_data[9] == $past(rx_data[0])) else $error("merge lost a slot");
  c_preset_b: cover property (manual_q && preset == tpsmr_pkg::TPSMR_PRESET_B && is_ctrl);
  c_red_switch: cover property (manual_q && preset == tpsmr_pkg::TPSMR_PRESET_C && $rose(red_p10));
  c_button_step: cover property (btn_q && !btn_prev ##1 preset == tpsmr_pkg::TPSMR_PRESET_B);
  c_apb_advance: cover property (apb_adv);

endmodule

// *** bench/tpsmr_far_end.sv ***
// Model of the ten audio modules that face the hub's ports.
// Assumes the hub owns slot timing and sets slot_idx; the bench says which are on line.
`timescale 1ns/1ps

module tpsmr_far_end
(
  // Frame position from the hub
  input wire logic [6:0] slot_idx,
  // Modules on line
  input wire logic [9:0] valid_mask,
  // Streams into the hub
  output logic [9:0] rx_valid,
  output logic [9:0] rx_occ,
  output logic [9:0][23:0] rx_data
);
  // ****************************************************************
  // Slot ownership
  // ****************************************************************
  always_comb
  begin
    rx_valid = valid_mask;
    for (int p = 0; p < 10; p++)
    begin
      // At most one on-line owner per slot, audio and control alike; off-line modules claim every odd slot
      rx_occ[p] = valid_mask[p] ? (slot_idx % 7'h0A == 7'(p)) : slot_idx[0];
      rx_data[p] = {4'hA, 4'(p), 9'h000, slot_idx};
      // Off-line modules show garbage
      if (!valid_mask[p])
        rx_data[p] = ~rx_data[p];
    end
  end
endmodule

// *** bench/test_ten_port_stream_merge_router.sv ***
// Self-checking bench of the ten-port stream merge router.
// Assumes the far-end model and the router sit in one pclk domain.
`timescale 1ns/1ps

module test_ten_port_stream_merge_router;
  logic pclk, presetn, psel, penable, pwrite, net_manual, cfg_button;
  logic pready, pslverr, tx_sof, led_auto, led_manual, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] rx_valid, rx_occ, tx_occ, led_active, vmask;
  logic [9:0][23:0] rx_data, tx_data;
  logic [6:0] slot_idx, tx_slot;
  logic [2:0] led_preset;
  int fails, checks, pre;

  tpsmr_router dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .net_manual(net_manual), .cfg_button(cfg_button),
    .rx_valid(rx_valid), .rx_occ(rx_occ), .rx_data(rx_data), .slot_idx(slot_idx),
    .tx_sof(tx_sof), .tx_slot(tx_slot), .tx_occ(tx_occ), .tx_data(tx_data),
    .led_auto(led_auto), .led_manual(led_manual), .led_preset(led_preset),
    .led_active(led_active));
  tpsmr_far_end far_u (.slot_idx(slot_idx), .valid_mask(vmask), .rx_valid(rx_valid),
    .rx_occ(rx_occ), .rx_data(rx_data));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: %s got %h", $time, m, got);
    end
  endtask

  function automatic logic [23:0] word(int p, int s);
    return {4'hA, 4'(p), 9'h000, 7'(s)};
  endfunction

  // Source port of tx port q in slot s, -1 when empty
  function automatic int src(int q, int s);
    int o;
    int red;
    o = s % 10;
    red = vmask[8] ? 8 : 9;
    if (!net_manual || pre == 0 || (pre == 1 && s >= 64))
      return vmask[o] ? o : -1;
    if (pre == 1 && q == 9)
      return (o < 9 && vmask[o]) ? o : -1;
    if (pre == 1)
      return (o == 9 && vmask[9]) ? 9 : -1;
    if (q >= 7)
      return (o < 8 && vmask[o]) ? o : -1;
    return (o == red && vmask[red]) ? red : -1;
  endfunction

  task check_frame(input string what);
    int s;
    int e;
    logic [9:0] eo;
    repeat (78)
    begin
      @(posedge pclk);
      #1;
      s = tx_slot;
      cmp(tx_sof, s == 0, "sof");
      cmp(slot_idx, (s + 1) % (tpsmr_pkg::AUDIO_SLOTS + tpsmr_pkg::CTRL_CHANNELS), "slot");
      for (int q = 0; q < 10; q++)
      begin
        e = src(q, s);
        eo[q] = e >= 0;
        if (e >= 0)
          cmp(tx_data[q], word(e, s), what);
      end
      cmp(tx_occ, eo, what);
    end
  endtask

  task set(input logic m, input logic [9:0] v);
    @(posedge pclk);
    net_manual <= m;
    vmask <= v;
    repeat (160) @(posedge pclk);
    #1;
  endtask

  task press();
    @(posedge pclk);
    cfg_button <= 1'h1;
    repeat (4) @(posedge pclk);
    cfg_button <= 1'h0;
    repeat (4) @(posedge pclk);
    pre = (pre + 1) % 3;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    cmp(n < 50, 1'h1, "apb wait");
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_auto();
    set(1'h0, 10'h3F5);
    check_frame("auto");
    cmp(led_active, vmask, "active");
    cmp({led_auto, led_manual}, 2'h2, "auto leds");
    press();
    set(1'h0, 10'h3F5);
    cmp(led_preset, 3'h2, "preset led");
    check_frame("auto held");
  endtask

  task t_manual_b();
    set(1'h1, 10'h2FF);
    cmp({led_auto, led_manual, led_preset}, 5'h0A, "b leds");
    check_frame("preset b");
    cmp(led_active, vmask, "active b");
  endtask

  task t_manual_c();
    apb(1'h1, tpsmr_pkg::REG_CTRL, 32'h00000001);
    pre = 2;
    set(1'h1, 10'h3FF);
    cmp(led_preset, 3'h4, "c led");
    check_frame("preset c");
    apb(1'h0, tpsmr_pkg::REG_STATUS, 32'h00000000);
    cmp(rd, {6'h00, vmask, 11'h000, 1'h0, 3'h4, 1'h1}, "status c");
    set(1'h1, 10'h2FF);
    check_frame("redundant");
    apb(1'h0, tpsmr_pkg::REG_STATUS, 32'h00000000);
    cmp(rd, {6'h00, vmask, 11'h000, 1'h1, 3'h4, 1'h1}, "status red");
  endtask

  task t_apb();
    apb(1'h0, 12'h008, 32'h00000000);
    cmp(er, 1'h1, "unmapped error");
    cmp(rd, 32'h00000000, "unmapped data");
    apb(1'h0, tpsmr_pkg::REG_CTRL, 32'h00000000);
    cmp(er, 1'h0, "ctrl read error");
    cmp(rd, 32'h00000000, "ctrl read");
    apb(1'h1, tpsmr_pkg::REG_STATUS, 32'hFFFFFFFF);
    apb(1'h0, tpsmr_pkg::REG_STATUS, 32'h00000000);
    cmp(rd, {6'h00, vmask, 11'h000, 1'h1, 3'h4, 1'h1}, "status write");
    press();
    set(1'h1, 10'h3FF);
    cmp(led_preset, 3'h1, "wrap to a");
    check_frame("preset a");
  endtask

  // ****************************************************************
  // Clock, reset, sequence
  // ****************************************************************
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    #(25 * 10000);
    fails++;
    print_verdict();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, net_manual, cfg_button} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    vmask = 10'h3F5;
    fails = 0;
    checks = 0;
    pre = 0;
    repeat (8) @(posedge pclk);
    #1;
    cmp(led_preset, 3'h1, "reset preset");
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_auto();
    t_manual_b();
    t_manual_c();
    t_apb();
    print_verdict();
  end
endmodule
